//--- common/gcr_pkg.sv
// Package for the gas control and result register block: offsets, fields, timing.
// Assumes a byte-wide register port driven by the serial interface logic outside.
package gcr_pkg;

    // Register offsets
    localparam logic [7:0] GCR_OFS_STATUS = 8'h1D;
    localparam logic [7:0] GCR_OFS_PRESS_H = 8'h1F;
    localparam logic [7:0] GCR_OFS_PRESS_M = 8'h20;
    localparam logic [7:0] GCR_OFS_PRESS_L = 8'h21;
    localparam logic [7:0] GCR_OFS_TEMP_H = 8'h22;
    localparam logic [7:0] GCR_OFS_TEMP_M = 8'h23;
    localparam logic [7:0] GCR_OFS_TEMP_L = 8'h24;
    localparam logic [7:0] GCR_OFS_HUM_H = 8'h25;
    localparam logic [7:0] GCR_OFS_HUM_L = 8'h26;
    localparam logic [7:0] GCR_OFS_GAS_H = 8'h2A;
    localparam logic [7:0] GCR_OFS_GAS_L = 8'h2B;
    localparam logic [7:0] GCR_OFS_GAS_CTRL = 8'h71;

    // Field positions
    localparam int GCR_BIT_NEW_DATA = 7;
    localparam int GCR_BIT_GAS_MEAS = 6;
    localparam int GCR_BIT_MEASURING = 5;
    localparam int GCR_BIT_RUN_GAS = 4;
    localparam int GCR_BIT_GAS_VALID = 5;
    localparam int GCR_BIT_HEAT_STAB = 4;

    // Values after reset and set-point limit
    localparam logic [19:0] GCR_SKIP_VALUE = 20'h80000;
    localparam logic [7:0] GCR_CTRL_RESET = 8'h00;
    localparam logic [3:0] GCR_MAX_SETPOINT = 4'h9;

    // Timing: 1 ms wait step at 125 MHz
    localparam int GCR_CLK_MHZ = 125;
    localparam int GCR_STEP_US = 1000;
    localparam int GCR_STEP_CYCLES = GCR_STEP_US * GCR_CLK_MHZ;

    // Conversion sequencer states
    typedef enum logic [4:0] {
        GCR_IDLE = 5'b00001,
        GCR_TPH = 5'b00010,
        GCR_HEAT = 5'b00100,
        GCR_GAS = 5'b01000,
        GCR_STORE = 5'b10000
    } gcr_state_e;

endpackage

//--- hdl/gcr_regs.sv
// Gas control and result register block of the environmental sensor.
// Assumes the serial interface logic presents a byte-wide register port and
// an analogue front end that returns raw results with a done pulse.
`timescale 1ns/100ps
module gcr_regs
    import gcr_pkg::*;
#(
    parameter int STEP_CYCLES = GCR_STEP_CYCLES // Cycles per 1 ms wait step
) (
    input wire logic sys_clk, // System clock, 125 MHz
    input wire logic resetn, // Asynchronous reset, active low
    input wire logic reg_wr, // Register write strobe
    input wire logic [7:0] reg_addr, // Register offset
    input wire logic [7:0] reg_wdata, // Write data
    output logic [7:0] reg_rdata, // Read data, results from shadow copy
    input wire logic reg_burst, // High during a host read burst
    input wire logic forced_start, // Pulse: start a forced-mode cycle
    input wire logic [7:0] gas_wait, // Wait setting of selected set-point
    input wire logic press_skip, // Pressure oversampling is off
    input wire logic temp_skip, // Temperature oversampling is off
    input wire logic conv_done, // Pulse: front end finished a phase
    input wire logic [19:0] fe_press, // Raw pressure from front end
    input wire logic [19:0] fe_temp, // Raw temperature from front end
    input wire logic [15:0] fe_hum, // Raw humidity from front end
    input wire logic [9:0] fe_gas, // Raw gas resistance from front end
    input wire logic [3:0] fe_gas_range, // Gas ADC range from front end
    input wire logic fe_heat_stable, // Heater reached its target
    output logic tph_start, // Level: run temperature, pressure, humidity
    output logic gas_start, // Level: run gas conversion
    output logic heat_on, // Level: heater driven
    output logic [3:0] heat_index // Set-point in use by the heater
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    gcr_state_e state; // Sequencer state
    gcr_state_e next_state; // Next sequencer state
    logic [7:0] gas_control; // Control register
    logic [3:0] setpoint_selector; // Selected heater set-point
    logic run_gas; // Gas conversions enabled
    logic gas_real; // Current cycle has a real gas slot
    logic [19:0] press_res; // Pressure result
    logic [19:0] temp_res; // Temperature result
    logic [15:0] hum_res; // Humidity result
    logic [9:0] gas_res; // Gas resistance result
    logic [3:0] gas_range; // Gas ADC range
    logic gas_valid; // Last gas slot was real
    logic heat_stab; // Heater was stable
    logic new_data; // New data flag
    logic [3:0] meas_index; // Gas measurement index
    logic [13:0] wait_left; // Remaining wait steps
    logic [13:0] wait_load; // Scaled wait length
    logic step_tick; // One wait step elapsed
    logic [79:0] live_set; // Live result set
    logic [79:0] shadow_set; // Stable copy for reads
    logic rd_new_data; // Flag as frozen for reads
    logic [7:0] status_byte; // Status register image

    assign setpoint_selector = gas_control[3:0];
    assign run_gas = gas_control[GCR_BIT_RUN_GAS];

    ////////////////////////////////////////////////////////////////////////
    // Control register write
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            gas_control <= GCR_CTRL_RESET;
        end else if (reg_wr && reg_addr == GCR_OFS_GAS_CTRL) begin
            gas_control <= {3'h0, reg_wdata[4:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wait length: 6-bit count times 1, 4, 16 or 64
    always_comb begin
        unique case (gas_wait[7:6])
            2'b00: wait_load = {8'h00, gas_wait[5:0]};
            2'b01: wait_load = {6'h00, gas_wait[5:0], 2'h0};
            2'b10: wait_load = {4'h0, gas_wait[5:0], 4'h0};
            2'b11: wait_load = {2'h0, gas_wait[5:0], 6'h00};
        endcase
    end

    gcr_tick #(
        .STEP_CYCLES(STEP_CYCLES)
    ) u_tick (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .run(state == GCR_HEAT && wait_left != 14'h0),
        .tick(step_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sequencer next state: every cycle passes through a gas slot
    always_comb begin
        next_state = state;
        unique case (state)
            GCR_IDLE: begin
                if (forced_start) begin
                    next_state = GCR_TPH;
                end
            end
            GCR_TPH: begin
                if (conv_done) begin
                    next_state = GCR_HEAT;
                end
            end
            GCR_HEAT: begin
                if (wait_left == 14'h0) begin
                    next_state = GCR_GAS;
                end
            end
            GCR_GAS: begin
                if (conv_done) begin
                    next_state = GCR_STORE;
                end
            end
            GCR_STORE: begin
                next_state = GCR_IDLE;
            end
            default: begin
                next_state = GCR_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer state register
    // Illegal codes fall back to idle through the next-state default
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state <= GCR_IDLE;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Cycle setup: gas real only when enabled at forced start
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            gas_real <= 1'b0;
            heat_index <= 4'h0;
        end else if (state == GCR_IDLE && forced_start) begin
            gas_real <= run_gas;
            // Out-of-range selector falls back to the last set-point
            heat_index <= (setpoint_selector > GCR_MAX_SETPOINT) ?
                GCR_MAX_SETPOINT : setpoint_selector;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wait countdown for the heat phase; dummy slots skip the wait
    // A zero count means no wait: the gas phase follows after one cycle
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wait_left <= 14'h0;
        end else if (state == GCR_TPH && conv_done) begin
            wait_left <= gas_real ? wait_load : 14'h0;
        end else if (step_tick && wait_left != 14'h0) begin
            wait_left <= wait_left - 14'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Front-end controls
    assign tph_start = (state == GCR_TPH);
    assign heat_on = (state == GCR_HEAT || state == GCR_GAS) && gas_real;
    assign gas_start = (state == GCR_GAS) && gas_real;

    ////////////////////////////////////////////////////////////////////////
    // Temperature, pressure, humidity results captured at end of phase
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            press_res <= GCR_SKIP_VALUE;
            temp_res <= GCR_SKIP_VALUE;
            hum_res <= 16'h0;
        end else if (state == GCR_TPH && conv_done) begin
            // Skipped channels read the mid-scale marker
            press_res <= press_skip ? GCR_SKIP_VALUE : fe_press;
            temp_res <= temp_skip ? GCR_SKIP_VALUE : fe_temp;
            hum_res <= fe_hum;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Gas status captured at end of each gas slot, gas results only at end of a real one
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            gas_res <= 10'h0;
            gas_range <= 4'h0;
            gas_valid <= 1'b0;
            heat_stab <= 1'b0;
            meas_index <= 4'h0;
        end else if (state == GCR_GAS && conv_done) begin
            gas_valid <= gas_real;
            heat_stab <= gas_real && fe_heat_stable;
            meas_index <= heat_index;
            if (gas_real) begin
                gas_res <= fe_gas;
                gas_range <= fe_gas_range;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // New data: set at store, cleared when the status byte is read out
    // New results win over a clear in the same cycle
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            new_data <= 1'b0;
        end else if (state == GCR_STORE) begin
            new_data <= 1'b1;
        end else if (!reg_burst && rd_new_data && reg_addr == GCR_OFS_STATUS) begin
            new_data <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Live set and shadow copy; the shadow only updates between bursts
    // so a burst read never mixes two measurement cycles
    assign live_set = {press_res, temp_res, hum_res, gas_res, gas_range,
        gas_valid, heat_stab, new_data, meas_index, 3'h0};

    gcr_shadow #(
        .WIDTH(80)
    ) u_shadow (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .hold(reg_burst),
        .live(live_set),
        .shadow(shadow_set)
    );

    assign rd_new_data = shadow_set[7];

    ////////////////////////////////////////////////////////////////////////
    // Status byte: busy flags are live, the rest from the shadow
    // so a host polling inside a burst still sees the cycle end
    always_comb begin
        status_byte = 8'h00;
        status_byte[GCR_BIT_NEW_DATA] = shadow_set[7];
        status_byte[GCR_BIT_GAS_MEAS] = (state == GCR_GAS) && gas_real;
        status_byte[GCR_BIT_MEASURING] = (state != GCR_IDLE);
        status_byte[3:0] = shadow_set[6:3];
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data register; unmapped offsets read zero
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else begin
            unique case (reg_addr)
                GCR_OFS_STATUS: reg_rdata <= status_byte;
                GCR_OFS_PRESS_H: reg_rdata <= shadow_set[79:72];
                GCR_OFS_PRESS_M: reg_rdata <= shadow_set[71:64];
                // Result bits 3:0 in the upper nibble, low nibble always reads zero
                GCR_OFS_PRESS_L: reg_rdata <= {shadow_set[63:60], 4'h0};
                GCR_OFS_TEMP_H: reg_rdata <= shadow_set[59:52];
                GCR_OFS_TEMP_M: reg_rdata <= shadow_set[51:44];
                GCR_OFS_TEMP_L: reg_rdata <= {shadow_set[43:40], 4'h0};
                GCR_OFS_HUM_H: reg_rdata <= shadow_set[39:32];
                GCR_OFS_HUM_L: reg_rdata <= shadow_set[31:24];
                GCR_OFS_GAS_H: reg_rdata <= shadow_set[23:16];
                GCR_OFS_GAS_L: reg_rdata <= {shadow_set[15:14], shadow_set[9:8], shadow_set[13:10]};
                GCR_OFS_GAS_CTRL: reg_rdata <= gas_control;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // Heater set-point registers are used as given; the host must keep them
    // steady while measuring is reported, since the wait setting is only
    // sampled once the TPH phase ends and a late change would mix two
    // set-points within one cycle.
endmodule

//--- hdl/gcr_shadow.sv
// Shadow copy of the result set, frozen while a multi-byte read burst runs.
// Assumes hold goes high for the length of a host read burst.
`timescale 1ns/100ps
module gcr_shadow #(
    parameter int WIDTH = 80 // Bits in the result set
) (
    input wire logic sys_clk, // System clock
    input wire logic resetn, // Asynchronous reset, active low
    input wire logic hold, // Freeze the copy while high
    input wire logic [WIDTH-1:0] live, // Live result set
    output logic [WIDTH-1:0] shadow // Stable copy for the host
);
    ////////////////////////////////////////////////////////////////////////
    // Follow the live set only while no read burst is running
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            shadow <= '0;
        end else if (!hold) begin
            shadow <= live;
        end
    end
endmodule

//--- hdl/gcr_tick.sv
// Divider producing a one-cycle enable once per wait step.
// Assumes a single free-running clock.
`timescale 1ns/100ps
module gcr_tick #(
    parameter int STEP_CYCLES = 125000 // Clock cycles per wait step
) (
    input wire logic sys_clk, // System clock
    input wire logic resetn, // Asynchronous reset, active low
    input wire logic run, // Count while high, clear while low
    output logic tick // One-cycle pulse each step
);
    logic [31:0] count; // Cycles within current step

    ////////////////////////////////////////////////////////////////////////
    // Step counter, restarts whenever the wait is not running
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            count <= 32'h0;
            tick <= 1'b0;
        end else if (!run) begin
            count <= 32'h0;
            tick <= 1'b0;
        end else if (count == 32'(STEP_CYCLES - 1)) begin
            count <= 32'h0;
            tick <= 1'b1;
        end else begin
            count <= count + 32'h1;
            tick <= 1'b0;
        end
    end
endmodule

//--- tb/gcr_front_end.sv
// Front end model: answers each conversion phase with a done pulse and data.
// Assumes the block raises one phase level at a time.
`timescale 1ns/100ps
module gcr_front_end (
    input wire logic sys_clk, // System clock
    input wire logic resetn, // Reset, active low
    input wire logic tph_start, // TPH phase level
    input wire logic gas_start, // Real gas phase level
    input wire logic dummy, // Cycle has a dummy gas slot
    input wire logic [3:0] delay, // Answer latency
    input wire logic [19:0] p, // Pressure to report
    input wire logic [19:0] t, // Temperature to report
    input wire logic [15:0] h, // Humidity to report
    input wire logic [9:0] g, // Gas resistance to report
    input wire logic [3:0] rng, // Gas range to report
    input wire logic stab, // Heater stability to report
    output logic conv_done, // Phase finished pulse
    output logic [19:0] fe_press, // Pressure
    output logic [19:0] fe_temp, // Temperature
    output logic [15:0] fe_hum, // Humidity
    output logic [9:0] fe_gas, // Gas resistance
    output logic [3:0] fe_gas_range, // Gas range
    output logic fe_heat_stable // Heater stable
);
    logic tph_d; // Last TPH level
    logic gas_d; // Last gas level
    logic dum_pend; // Dummy slot still to answer
    int cnt; // Cycles to the answer, -1 when idle
    // Data valid only with the pulse; inverted otherwise so stale data never matches
    assign fe_press = conv_done ? p : ~p;
    assign fe_temp = conv_done ? t : ~t;
    assign fe_hum = conv_done ? h : ~h;
    assign fe_gas = conv_done ? g : ~g;
    assign fe_gas_range = conv_done ? rng : ~rng;
    assign fe_heat_stable = conv_done ? stab : ~stab;
    // Answer each phase after the chosen latency, a dummy gas slot after 3 cycles more
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            {tph_d, gas_d, dum_pend, conv_done} <= 4'h0;
            cnt <= -1;
        end else begin
            tph_d <= tph_start;
            gas_d <= gas_start;
            conv_done <= 1'b0;
            dum_pend <= 1'b0;
            if ((tph_start && !tph_d) || (gas_start && !gas_d)) begin
                cnt <= int'(delay);
            end else if (dum_pend) begin
                cnt <= int'(delay) + 3; // Dummy gas slot also needs an answer
            end else if (cnt == 0) begin
                conv_done <= 1'b1;
                cnt <= -1;
                dum_pend <= tph_start && dummy;
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule

//--- tb/gcr_regs_properties.sv
// Checker for the gas control and result register block, bound to its ports.
// Assumes the host leaves the gas control register alone while a cycle runs.
`timescale 1ns/100ps
module gcr_regs_properties
    import gcr_pkg::*;
#(
    parameter int STEP_CYCLES = 4 // Cycles per wait step
) (
    input wire logic sys_clk, // System clock
    input wire logic resetn, // Reset, active low
    input wire logic reg_wr, // Write strobe
    input wire logic [7:0] reg_addr, // Register offset
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic [7:0] reg_rdata, // Read data
    input wire logic [7:0] gas_wait, // Wait setting
    input wire logic conv_done, // Phase finished
    input wire logic tph_start, // TPH phase level
    input wire logic gas_start, // Real gas phase level
    input wire logic heat_on, // Heater driven
    input wire logic [3:0] heat_index // Set-point in use
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////
    logic [7:0] ctrl_q; // Mirror of the gas control register
    int heat_cnt; // Heating cycles before the gas phase
    int exp_wait; // Heating cycles the wait setting asks for
    assign exp_wait = int'(gas_wait[5:0]) * (1 << (2 * gas_wait[7:6])) * STEP_CYCLES;
    // Mirror host writes, upper bits read back as zero
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= 8'h00;
        end else if (reg_wr && reg_addr == GCR_OFS_GAS_CTRL) begin
            ctrl_q <= {3'h0, reg_wdata[4:0]};
        end
    end
    // Count heating cycles, restart with each TPH phase
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            heat_cnt <= 0;
        end else if (tph_start) begin
            heat_cnt <= 0;
        end else if (heat_on && !gas_start) begin
            heat_cnt <= heat_cnt + 1;
        end
    end
    ////////////////////////////////////////
    property p_ctrl_rb;
        (reg_addr == GCR_OFS_GAS_CTRL && !reg_wr) [*2] |=> reg_rdata == ctrl_q;
    endproperty
    a_ctrl_rb: assert property (p_ctrl_rb) else $error("control readback wrong");
    property p_run_gas;
        gas_start |-> ctrl_q[GCR_BIT_RUN_GAS];
    endproperty
    a_run_gas: assert property (p_run_gas) else $error("gas phase without enable");
    property p_heat_idx;
        heat_on |-> heat_index == ((ctrl_q[3:0] > 4'h9) ? 4'h9 : ctrl_q[3:0]);
    endproperty
    a_heat_idx: assert property (p_heat_idx) else $error("wrong set-point in use");
    property p_tph_ends;
        tph_start && conv_done |=> !tph_start;
    endproperty
    a_tph_ends: assert property (p_tph_ends) else $error("TPH phase did not end");
    property p_gas_ends;
        gas_start && conv_done |=> !gas_start;
    endproperty
    a_gas_ends: assert property (p_gas_ends) else $error("gas phase did not end");
    property p_tph_to_heat;
        tph_start && conv_done && ctrl_q[GCR_BIT_RUN_GAS] |=> heat_on;
    endproperty
    a_tph_to_heat: assert property (p_tph_to_heat) else $error("heater not started");
    property p_wait_len;
        $rose(gas_start) |-> heat_cnt + 1 >= exp_wait && heat_cnt <= exp_wait + 3;
    endproperty
    a_wait_len: assert property (p_wait_len) else $error("heater wait length wrong");
    property p_meas_live;
        $past(tph_start) && $past(reg_addr) == GCR_OFS_STATUS |-> reg_rdata[5] && !reg_rdata[6];
    endproperty
    a_meas_live: assert property (p_meas_live) else $error("measuring flags wrong");
    property p_gas_live;
        $past(gas_start) && $past(reg_addr) == GCR_OFS_STATUS |-> reg_rdata[6] && reg_rdata[5];
    endproperty
    a_gas_live: assert property (p_gas_live) else $error("gas measuring flag low");
    c_real_gas: cover property ($rose(gas_start));
    c_dummy: cover property (tph_start && conv_done && !ctrl_q[GCR_BIT_RUN_GAS]);
    c_write: cover property (reg_wr && reg_addr == GCR_OFS_GAS_CTRL);
endmodule

bind gcr_regs gcr_regs_properties #(.STEP_CYCLES(STEP_CYCLES)) u_props (.sys_clk(sys_clk), .resetn(resetn),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .gas_wait(gas_wait),
    .conv_done(conv_done), .tph_start(tph_start), .gas_start(gas_start), .heat_on(heat_on),
    .heat_index(heat_index));

//--- tb/test_gcr_regs.sv
// Testbench: forced cycles with real and dummy gas slots, register reads.
// Assumes the front end model and the bound checker.
`timescale 1ns/100ps
module test_gcr_regs;
    import gcr_pkg::*;
    localparam int STEP = 4; // Short wait step
    logic sys_clk = 0, resetn = 0, reg_wr = 0, reg_burst = 0, forced_start = 0, press_skip = 0, temp_skip = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, gas_wait = 0, reg_rdata;
    logic conv_done, tph_start, gas_start, heat_on, fe_heat_stable;
    logic [3:0] heat_index, fe_gas_range, mr = 0, mdly = 2;
    logic [19:0] fe_press, fe_temp, mp = 0, mt = 0;
    logic [15:0] fe_hum, mh = 0;
    logic [9:0] fe_gas, mg = 0;
    logic ms = 0, mdum = 0, rd_v = 0, rd_p = 0;
    logic [7:0] exp_q[$]; // Expected read bytes, oldest first
    logic [7:0] addrs[10] = '{8'h1F, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h2A, 8'h2B};
    logic [31:0] seed = 32'd86; // Random state
    int num_errors = 0, comparisons = 0;
    always #4 sys_clk = ~sys_clk;
    gcr_regs #(.STEP_CYCLES(STEP)) dut (.sys_clk(sys_clk), .resetn(resetn), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_burst(reg_burst),
        .forced_start(forced_start), .gas_wait(gas_wait), .press_skip(press_skip), .temp_skip(temp_skip),
        .conv_done(conv_done), .fe_press(fe_press), .fe_temp(fe_temp), .fe_hum(fe_hum), .fe_gas(fe_gas),
        .fe_gas_range(fe_gas_range), .fe_heat_stable(fe_heat_stable), .tph_start(tph_start),
        .gas_start(gas_start), .heat_on(heat_on), .heat_index(heat_index));
    gcr_front_end u_fe (.sys_clk(sys_clk), .resetn(resetn), .tph_start(tph_start), .gas_start(gas_start),
        .dummy(mdum), .delay(mdly), .p(mp), .t(mt), .h(mh), .g(mg), .rng(mr), .stab(ms), .conv_done(conv_done),
        .fe_press(fe_press), .fe_temp(fe_temp), .fe_hum(fe_hum), .fe_gas(fe_gas), .fe_gas_range(fe_gas_range),
        .fe_heat_stable(fe_heat_stable));
    ////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // Present an offset and note the byte it must return
    task automatic rd(input logic [7:0] a, input logic b, input logic [7:0] e);
        @(posedge sys_clk);
        {reg_addr, reg_burst, rd_v} <= {a, b, 1'b1};
        exp_q.push_back(e);
        @(posedge sys_clk);
        rd_v <= 1'b0;
    endtask
    // Compare each read byte one cycle after its offset was taken
    always @(posedge sys_clk) begin
        rd_p <= rd_v;
        if (rd_p) begin
            chk(reg_rdata, exp_q.pop_front());
        end
    end
    ////////////////////////////////////////
    initial begin
        logic [31:0] r, r2;
        logic [7:0] ctl;
        logic [19:0] p, t;
        logic [9:0] g;
        logic [3:0] rg, idx;
        logic [79:0] old_r, new_r;
        int n;
        old_r = {GCR_SKIP_VALUE, 4'h0, GCR_SKIP_VALUE, 4'h0, 32'h0};
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rd(GCR_OFS_GAS_CTRL, 1'b0, GCR_CTRL_RESET);
        for (int i = 0; i < 12; i++) begin
            r = xs();
            r2 = xs();
            ctl = {r[7:5], i % 4 != 3, i[3:0]};
            idx = (ctl[3:0] > 4'h9) ? 4'h9 : ctl[3:0];
            wr(GCR_OFS_GAS_CTRL, ctl);
            rd(GCR_OFS_GAS_CTRL, 1'b0, {3'h0, ctl[4:0]});
            // Heater wait setting changes only while no cycle runs
            {gas_wait, press_skip, temp_skip} <= {i[1:0], 3'h0, r[2:0], i == 2, i == 5};
            {mp, mt, mh, mg, mr, ms} <= {r[31:12], r2[19:0], r2[31:16], r2[29:20], r2[3:0], r[11]};
            {mdly, mdum} <= {2'b00, r[9:8] + 2'd2, !ctl[4]};
            p = (i == 2) ? GCR_SKIP_VALUE : r[31:12];
            t = (i == 5) ? GCR_SKIP_VALUE : r2[19:0];
            g = ctl[4] ? r2[29:20] : old_r[15:6];
            rg = ctl[4] ? r2[3:0] : old_r[3:0];
            new_r = {p, 4'h0, t, 4'h0, r2[31:16], g, ctl[4], ctl[4] & r[11], rg};
            @(posedge sys_clk);
            {forced_start, reg_addr, reg_burst} <= {1'b1, GCR_OFS_STATUS, 1'b1};
            // Poll the live measuring flag, retrigger once while busy
            for (n = 0; n < 20000; n++) begin
                @(posedge sys_clk);
                if (n > 4 && reg_rdata[GCR_BIT_MEASURING] === 1'b0) break;
                forced_start <= (n == 5) && (tph_start === 1'b1);
            end
            if (n == 20000) begin
                chk(8'h01, 8'h00);
                summarize();
            end
            for (int k = 0; k < 10; k++) rd(addrs[k], 1'b1, old_r[79 - 8 * k -: 8]);
            rd(8'h00, 1'b0, 8'h00);
            rd(GCR_OFS_STATUS, 1'b0, {4'h8, idx});
            rd(GCR_OFS_STATUS, 1'b0, {4'h0, idx});
            for (int k = 0; k < 10; k++) rd(addrs[k], 1'b0, new_r[79 - 8 * k -: 8]);
            old_r = new_r;
        end
        repeat (3) @(posedge sys_clk);
        summarize();
    end
endmodule
